// ==== hw/wdc_pkg.sv ====
// Package with port addresses, register indices, field positions and timing for the watchdog
package wdc_pkg;
  // Host I/O port addresses
  localparam logic [15:0] IDX_PORT = 16'h004E;
  localparam logic [15:0] DAT_PORT = 16'h004F;
  // Sequence bytes on the index port
  localparam logic [7:0] UNLOCK_KEY = 8'h87;
  localparam logic [7:0] LOCK_KEY = 8'hAA;
  // Configuration indices
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_COUNT_UNIT_SELECT = 8'hF3;
  localparam logic [7:0] IDX_TIMEOUT_COUNT = 8'hF4;
  localparam logic [7:0] IDX_WATCHDOG_CONTROL_STATUS = 8'hF5;
  localparam logic [7:0] WDT_LDN = 8'h08;
  // Field positions
  localparam int UNIT_MINUTE_BIT = 2;
  localparam int STAT_TIMEOUT_BIT = 4;
  localparam int STAT_FORCE_BIT = 5;
  localparam int STAT_INVERT_BIT = 6;
  // Reset values and fixed answers
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] IDLE_READ = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  // Time base
  localparam longint CLK_HZ = 125_000_000;
  localparam longint SEC_IN_NS = 1_000_000_000;
  localparam longint UNIT_SEC_NS = 1_000_000_000;
  localparam int CYC_PER_SEC = int'((UNIT_SEC_NS * CLK_HZ) / SEC_IN_NS);
  localparam int SEC_PER_MIN = 60;
  // Host access carried as one bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } wdc_io_req_t;
  // Configuration lock states
  typedef enum logic [1:0] {
    CFG_LOCKED,
    CFG_HALF,
    CFG_OPEN
  } wdc_cfg_state_t;
endpackage : wdc_pkg

// ==== hw/wdc_top.sv ====
// Watchdog timer behind an index/data configuration port pair
//
// Summary of operation
// - Two 0x87 index writes unlock configuration access.
// - F3, F4, F5 banked under watchdog device.
// - Unit bit 2: zero seconds, one minutes.
// - Unit and status registers reset to zero.
// - Nonzero count write loads and starts countdown.
// - Count read returns live counter value.
// - Zero count disables; resets to zero.
// - Load N times out after N units.
// - Status bit 6 inverts reported timeout polarity.
// - Status bit 5 forces timeout, self-clearing.
// - Status bit 4 flags timeout, read/write.
module wdc_top #(
  parameter int CYC_PER_SEC = wdc_pkg::CYC_PER_SEC, // Clock cycles per second
  parameter int SEC_PER_MIN = wdc_pkg::SEC_PER_MIN // Seconds per minute unit
) (
  input wire logic clk, // System clock, 125 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic io_wr, // Host I/O write strobe, one cycle
  input wire logic io_rd, // Host I/O read strobe, one cycle
  input wire logic [15:0] io_addr, // Host I/O port address
  input wire logic [7:0] io_wdata, // Host I/O write byte
  output logic [7:0] io_rdata, // Read byte, valid with io_rack
  output logic io_rack, // Read answer pulse, one cycle after io_rd
  output logic timeout_output // Watchdog timeout level, polarity per invert bit
);
  // Elaboration check: the time base cannot be built from smaller counts
  if (CYC_PER_SEC < 2 || SEC_PER_MIN < 1) begin : g_bad_time_base
    $error("wdc_top: time base counts too small");
  end

  // Configuration state and watchdog registers
  wdc_pkg::wdc_io_req_t req;
  wdc_pkg::wdc_cfg_state_t cfg_r;
  logic [7:0] index_r;
  logic [7:0] ldn_r;
  logic unit_min_r;
  logic [7:0] count_r;
  logic stat_to_r;
  logic invert_r;
  logic unit_tick;
  logic restart;

  // Host strobes come from logic on this clock, so they are used directly
  assign req = '{wr: io_wr, rd: io_rd, addr: io_addr, wdata: io_wdata};

  // Decoded host accesses
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic open_cfg;
  logic wdt_sel;
  logic load_cnt;
  logic expire;
  logic stat_wr;

  assign idx_wr = req.wr && (req.addr == wdc_pkg::IDX_PORT);
  assign open_cfg = (cfg_r == wdc_pkg::CFG_OPEN);
  // Data port accesses count only while unlocked
  assign dat_wr = open_cfg && req.wr && (req.addr == wdc_pkg::DAT_PORT);
  assign dat_rd = open_cfg && req.rd && (req.addr == wdc_pkg::DAT_PORT);
  // Watchdog registers answer only under their logical device
  assign wdt_sel = (ldn_r == wdc_pkg::WDT_LDN);
  assign stat_wr = dat_wr && wdt_sel && (index_r == wdc_pkg::IDX_WATCHDOG_CONTROL_STATUS);
  assign load_cnt = dat_wr && wdt_sel && (index_r == wdc_pkg::IDX_TIMEOUT_COUNT);
  // Final unit of a running count; stops the watchdog at zero
  assign expire = unit_tick && (count_r == wdc_pkg::COUNT_ONE) && !load_cnt;
  // A fresh load starts a full unit so N loads give N whole units
  assign restart = load_cnt;

  // Lock sequence: two keys in succession open, the lock byte closes
  // Strobes are single-cycle, so idle cycles between the keys do not break the pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= wdc_pkg::CFG_LOCKED;
    end else if (req.wr || req.rd) begin
      unique case (cfg_r)
        wdc_pkg::CFG_LOCKED: begin
          if (idx_wr && req.wdata == wdc_pkg::UNLOCK_KEY) begin
            cfg_r <= wdc_pkg::CFG_HALF;
          end
        end
        wdc_pkg::CFG_HALF: begin
          // Any other access between the keys breaks the sequence
          if (idx_wr && req.wdata == wdc_pkg::UNLOCK_KEY) begin
            cfg_r <= wdc_pkg::CFG_OPEN;
          end else begin
            cfg_r <= wdc_pkg::CFG_LOCKED;
          end
        end
        wdc_pkg::CFG_OPEN: begin
          if (idx_wr && req.wdata == wdc_pkg::LOCK_KEY) begin
            cfg_r <= wdc_pkg::CFG_LOCKED;
          end
        end
      endcase
    end
  end

  // Index latch; the lock byte is not kept as an index
  // The index survives a relock, so software need not rewrite it after unlocking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_r <= wdc_pkg::RESET_BYTE;
    end else if (idx_wr && open_cfg && req.wdata != wdc_pkg::LOCK_KEY) begin
      index_r <= req.wdata;
    end
  end

  // Logical device number
  // Written from any bank so software can always reach the device number
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldn_r <= wdc_pkg::RESET_BYTE;
    end else if (dat_wr && index_r == wdc_pkg::IDX_LDN) begin
      ldn_r <= req.wdata;
    end
  end

  // Count unit select; only bit 2 is kept, the rest is reserved
  // A unit change does not restart the divider; the new unit applies from the next second tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_min_r <= 1'b0;
    end else if (dat_wr && wdt_sel && index_r == wdc_pkg::IDX_COUNT_UNIT_SELECT) begin
      unit_min_r <= req.wdata[wdc_pkg::UNIT_MINUTE_BIT];
    end
  end

  wdc_unit_tick #(
    .CYC_PER_SEC(CYC_PER_SEC),
    .SEC_PER_MIN(SEC_PER_MIN)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .restart(restart),
    .minute_mode(unit_min_r),
    .unit_tick(unit_tick)
  );

  // Watchdog counter; a write of zero stops it, as does reaching zero
  // A load in the cycle of a unit tick wins, so the new count is kept whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= wdc_pkg::RESET_BYTE;
    end else if (load_cnt) begin
      count_r <= req.wdata;
    end else if (unit_tick && count_r != wdc_pkg::ZERO_BYTE) begin
      count_r <= count_r - wdc_pkg::COUNT_ONE;
    end
  end

  // Timeout flag: expiry or force sets it and wins over a software clear
  // A clear written in the cycle of an expiry is lost; software rereads to confirm
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_to_r <= 1'b0;
    end else if (expire || (stat_wr && req.wdata[wdc_pkg::STAT_FORCE_BIT])) begin
      stat_to_r <= 1'b1;
    end else if (stat_wr) begin
      stat_to_r <= req.wdata[wdc_pkg::STAT_TIMEOUT_BIT];
    end
  end

  // Polarity invert bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      invert_r <= 1'b0;
    end else if (stat_wr) begin
      invert_r <= req.wdata[wdc_pkg::STAT_INVERT_BIT];
    end
  end

  // Reported timeout level; trails the flag by one cycle to stay registered
  // The invert bit acts on the pin only; status bit 4 always reads true sense
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_output <= 1'b0;
    end else begin
      timeout_output <= stat_to_r ^ invert_r;
    end
  end

  // Read mux; force bit is write-only and always reads zero
  logic [7:0] rd_nxt;
  always_comb begin
    rd_nxt = wdc_pkg::IDLE_READ;
    if (dat_rd) begin
      // Unmapped indices under the open configuration read zero
      rd_nxt = wdc_pkg::ZERO_BYTE;
      if (index_r == wdc_pkg::IDX_LDN) begin
        rd_nxt = ldn_r;
      end else if (wdt_sel && index_r == wdc_pkg::IDX_COUNT_UNIT_SELECT) begin
        rd_nxt[wdc_pkg::UNIT_MINUTE_BIT] = unit_min_r;
      end else if (wdt_sel && index_r == wdc_pkg::IDX_TIMEOUT_COUNT) begin
        rd_nxt = count_r;
      end else if (wdt_sel && index_r == wdc_pkg::IDX_WATCHDOG_CONTROL_STATUS) begin
        rd_nxt[wdc_pkg::STAT_TIMEOUT_BIT] = stat_to_r;
        rd_nxt[wdc_pkg::STAT_INVERT_BIT] = invert_r;
      end
    end
  end

  // Read answer registered one cycle after the strobe
  // io_rdata holds between reads so a slow host may sample it late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= wdc_pkg::IDLE_READ;
      io_rack <= 1'b0;
    end else begin
      io_rack <= req.rd;
      if (req.rd) begin
        io_rdata <= rd_nxt;
      end
    end
  end
endmodule : wdc_top

// ==== hw/wdc_unit_tick.sv ====
// Time-base divider giving one pulse per second or per minute
module wdc_unit_tick #(
  parameter int CYC_PER_SEC = wdc_pkg::CYC_PER_SEC,
  parameter int SEC_PER_MIN = wdc_pkg::SEC_PER_MIN
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic restart, // Realign the divider to a fresh unit
  input wire logic minute_mode, // High for minute units
  output logic unit_tick // One-cycle pulse per elapsed unit
);
  // Elaboration check: the prescaler needs at least two cycles per second
  if (CYC_PER_SEC < 2 || SEC_PER_MIN < 1) begin : g_bad_divider
    $error("wdc_unit_tick: divider counts too small");
  end

  localparam int SW = $clog2(CYC_PER_SEC);
  localparam int MW = $clog2(SEC_PER_MIN + 1);
  localparam logic [SW-1:0] SEC_LAST = SW'(CYC_PER_SEC - 1);
  localparam logic [MW-1:0] MIN_LAST = MW'(SEC_PER_MIN - 1);

  logic [SW-1:0] cyc_r;
  logic [MW-1:0] sec_r;
  logic sec_tick;

  assign sec_tick = (cyc_r == SEC_LAST);

  // Cycle prescaler; restart keeps the first unit a full one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= '0;
    end else if (restart || sec_tick) begin
      cyc_r <= '0;
    end else begin
      cyc_r <= cyc_r + SW'(1);
    end
  end

  // Second counter for the minute base
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_r <= '0;
    end else if (restart) begin
      sec_r <= '0;
    end else if (sec_tick) begin
      sec_r <= (sec_r == MIN_LAST) ? '0 : sec_r + MW'(1);
    end
  end

  // Registered unit pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_tick <= 1'b0;
    end else begin
      unit_tick <= !restart && sec_tick && (!minute_mode || sec_r == MIN_LAST);
    end
  end
endmodule : wdc_unit_tick

// ==== test/test_wdc_top.sv ====
// Self-checking bench for the watchdog top
module test_wdc_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] IX = wdc_pkg::IDX_PORT;
  localparam logic [15:0] DP = wdc_pkg::DAT_PORT;
  logic clk, rst_n, io_wr, io_rd, io_rack, timeout_output;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  int n_mismatch = 0;
  int checked = 0;
  // Short units: 10 cycles a second, 3 seconds a minute
  wdc_top #(.CYC_PER_SEC(10), .SEC_PER_MIN(3)) wdc_top_i (.clk(clk), .rst_n(rst_n),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rack(io_rack), .timeout_output(timeout_output));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(negedge clk);
    io_wr = 1'b0;
  endtask : wr
  // Read strobe for one cycle, then a bounded wait for the answer pulse
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    int n;
    n = 0;
    @(negedge clk);
    io_rd = 1'b1;
    io_addr = a;
    @(negedge clk);
    io_rd = 1'b0;
    while (io_rack !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (io_rack !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    chk(what, exp, io_rdata);
  endtask : rd
  task automatic rw(input logic [7:0] i, input logic [7:0] d);
    wr(IX, i);
    wr(DP, d);
  endtask : rw
  task automatic rr(input logic [7:0] i, input logic [7:0] exp, input string what);
    wr(IX, i);
    rd(DP, exp, what);
  endtask : rr
  task automatic t_locked();
    rd(DP, 8'hFF, "locked data");
    wr(IX, 8'h87);
    rd(DP, 8'hFF, "broken key");
    wr(IX, 8'h87);
    wr(IX, 8'h87);
    rw(8'h07, 8'h08);
    rr(8'hF3, 8'h00, "unit reset");
    rr(8'hF4, 8'h00, "count reset");
    rr(8'hF5, 8'h00, "status reset");
  endtask : t_locked
  task automatic t_seconds();
    rw(8'hF4, 8'h03);
    repeat (15) @(negedge clk);
    rd(DP, 8'h02, "live count");
    repeat (6) @(negedge clk);
    rr(8'hF5, 8'h00, "still running");
    repeat (8) @(negedge clk);
    rr(8'hF5, 8'h10, "expired");
    chk("timeout_output", 8'h01, {7'h00, timeout_output});
    rr(8'hF4, 8'h00, "count idle");
  endtask : t_seconds
  task automatic t_minutes();
    rw(8'hF5, 8'h00);
    rw(8'hF3, 8'h04);
    rr(8'hF3, 8'h04, "minute unit");
    rw(8'hF4, 8'h01);
    repeat (20) @(negedge clk);
    rr(8'hF5, 8'h00, "minute running");
    repeat (15) @(negedge clk);
    rr(8'hF5, 8'h10, "minute expired");
  endtask : t_minutes
  task automatic t_force();
    rw(8'hF5, 8'h00);
    // The pin trails the status flag by one cycle
    @(negedge clk);
    chk("timeout_output", 8'h00, {7'h00, timeout_output});
    wr(DP, 8'h20);
    rd(DP, 8'h10, "forced");
    chk("timeout_output", 8'h01, {7'h00, timeout_output});
    wr(DP, 8'h40);
    rd(DP, 8'h40, "inverted idle");
    chk("timeout_output", 8'h01, {7'h00, timeout_output});
    wr(DP, 8'h60);
    rd(DP, 8'h50, "inverted forced");
    chk("timeout_output", 8'h00, {7'h00, timeout_output});
  endtask : t_force
  task automatic t_zero();
    rw(8'hF5, 8'h00);
    rw(8'hF3, 8'h00);
    rw(8'hF4, 8'h02);
    wr(DP, 8'h00);
    repeat (40) @(negedge clk);
    rr(8'hF5, 8'h00, "disabled");
  endtask : t_zero
  task automatic t_relock();
    rr(8'h07, 8'h08, "device number");
    rw(8'hF3, 8'h04);
    rw(8'h07, 8'h07);
    rr(8'hF3, 8'h00, "other device");
    wr(IX, 8'hAA);
    rd(DP, 8'hFF, "relocked");
    rd(IX, 8'hFF, "index read");
  endtask : t_relock
  // Reset for two cycles, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("timeout_output", 8'h00, {7'h00, timeout_output});
    t_locked();
    t_seconds();
    t_minutes();
    t_force();
    t_zero();
    t_relock();
    end_of_test();
  end
endmodule : test_wdc_top
bind wdc_top wdc_top_props wdc_top_props_i (.clk(clk), .rst_n(rst_n), .io_wr(io_wr),
  .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .io_rack(io_rack), .timeout_output(timeout_output));

// ==== test/wdc_top_props.sv ====
// Checker for the watchdog top: port timing, lock shadow and status answers
module wdc_top_props (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic io_wr, // Write strobe
  input wire logic io_rd, // Read strobe
  input wire logic [15:0] io_addr, // Port address
  input wire logic [7:0] io_wdata, // Write byte
  input wire logic [7:0] io_rdata, // Read byte
  input wire logic io_rack, // Read answer
  input wire logic timeout_output // Timeout level
);
  logic [1:0] key_r;
  logic [7:0] idx_r;
  logic [7:0] ldn_r;
  logic on_dat;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of lock state, index and device; a stray access breaks the key pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_r <= 2'h0;
      idx_r <= 8'h00;
      ldn_r <= 8'h00;
    end else if (io_wr || io_rd) begin
      if (key_r != 2'h2) begin
        key_r <= (io_wr && io_addr == wdc_pkg::IDX_PORT && io_wdata == wdc_pkg::UNLOCK_KEY) ?
                 key_r + 2'h1 : 2'h0;
      end else if (io_wr && io_addr == wdc_pkg::IDX_PORT) begin
        if (io_wdata == wdc_pkg::LOCK_KEY) key_r <= 2'h0;
        else idx_r <= io_wdata;
      end else if (io_wr && io_addr == wdc_pkg::DAT_PORT && idx_r == wdc_pkg::IDX_LDN) begin
        ldn_r <= io_wdata;
      end
    end
  end
  // Data port access that reaches the watchdog bank
  assign on_dat = io_addr == wdc_pkg::DAT_PORT && key_r == 2'h2 && ldn_r == wdc_pkg::WDT_LDN;
  property p_rack; io_rd |=> io_rack; endproperty
  a_rack: assert property (p_rack) else $error("read not answered");
  property p_rack_src; io_rack |-> $past(io_rd); endproperty
  a_rack_src: assert property (p_rack_src) else $error("answer without read");
  property p_idle;
    io_rd && (io_addr != wdc_pkg::DAT_PORT || key_r != 2'h2) |=> io_rdata == 8'hFF;
  endproperty
  a_idle: assert property (p_idle) else $error("locked read not idle");
  property p_ldn;
    io_rd && io_addr == wdc_pkg::DAT_PORT && key_r == 2'h2 && idx_r == wdc_pkg::IDX_LDN
      |=> io_rdata == ldn_r;
  endproperty
  a_ldn: assert property (p_ldn) else $error("device number readback");
  property p_unit;
    io_rd && on_dat && idx_r == wdc_pkg::IDX_COUNT_UNIT_SELECT
      |=> io_rdata[7:3] == 5'h00 && io_rdata[1:0] == 2'h0;
  endproperty
  a_unit: assert property (p_unit) else $error("unit reserved bits");
  property p_stat;
    io_rd && on_dat && idx_r == wdc_pkg::IDX_WATCHDOG_CONTROL_STATUS
      |=> io_rdata[7] == 1'b0 && io_rdata[5] == 1'b0 && io_rdata[3:0] == 4'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status write-only bit read");
  property p_force;
    io_wr && on_dat && idx_r == wdc_pkg::IDX_WATCHDOG_CONTROL_STATUS && io_wdata[6:5] == 2'h1
      |=> ##1 timeout_output;
  endproperty
  a_force: assert property (p_force) else $error("force not seen");
  property p_force_inv;
    io_wr && on_dat && idx_r == wdc_pkg::IDX_WATCHDOG_CONTROL_STATUS && io_wdata[6:5] == 2'h3
      |=> ##1 !timeout_output;
  endproperty
  a_force_inv: assert property (p_force_inv) else $error("invert not seen");
endmodule : wdc_top_props
